// ### hdl/pmc_power_mode_control.sv
/*
 power mode control: idle, stop and suspend entry, wake and reset for a small microcontroller core.
 assumes the cpu reports instruction completion, accepts halt and reset requests, and software reaches
 the registers over a 32-bit classic wishbone bus on clk_sys.
*/
// How it works
// - idle bit set halts cpu after the setting instruction completes
// - idle keeps registers and lets peripheral clocks run
// - enabled interrupt or reset ends idle; idle bit clears on the first idle cycle
// - after idle wake the interrupt is serviced, then the next instruction
// - reset ending idle restarts the cpu at address zero
// - an enabled watchdog eventually resets the device out of idle
// - stop bit halts internal oscillator, cpu and peripherals except clock detector
// - stop ends only on reset, then restarts at address zero
// - enabled missing-clock detector resets out of stop; software disables it
// - regulator stays on in stop unless shutdown bit set; then only pin resets
// - suspend bit halts cpu and fast oscillator, registers retained
// - in suspend only port match, externally clocked timer 3 and an enabled clock detector run
// - suspend ends on port match, timer 3 overflow, enabled comparator low, reset
// - non-reset suspend wake resumes after setting instruction, servicing wake interrupt
// - reset ending suspend restarts at address zero
// - stop and idle bits always read back as zero
// - power control holds stop bit 1, idle bit 0, six flags, reset zero
`timescale 1ns/100ps
module pmc_power_mode_control
   import pmc_pkg::*;
#(
   parameter int CLK_LOSS_TIMEOUT_CYC = PMC_CLK_LOSS_TIMEOUT_CYC,
   parameter int WATCHDOG_TIMEOUT_CYC = PMC_WATCHDOG_TIMEOUT_CYC
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // cpu side
   input wire logic instrDone,
   input wire logic irqPending,
   input wire logic cpuClkPresent,
   output logic cpuHalt,
   output logic cpuResetReq,
   output logic [15:0] resetVector,
   // wake sources from pins
   input wire logic resetPin_n,
   input wire logic portMatch,
   input wire logic timer3Overflow,
   input wire logic comparatorOut,
   // clock and power controls
   output logic intOscEnable,
   output logic periphClkEnable,
   output logic timer3ClkEnable,
   output logic portMatchEnable,
   output logic clkLossActive,
   output logic regulatorEnable,
   output logic [2:0] powerMode
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   pmc_mode_e mode_r, mode_nxt;
   logic [5:0] generalFlags_r;
   logic idleReq_r, stopReq_r, suspend_r, stopShutdown_r;
   logic [7:0] wakeCfg_r;
   logic [7:0] settle_r;
   logic [3:0] pinSync;
   logic resetPinSync_n, portMatchSync, t3OvfSync, cmpSync;
   logic wbHit, wbWrite;
   logic clkLossExpired, watchdogExpired, resetEvent, suspendWake;
   logic [7:0] readMux;

   assign resetPinSync_n = !pinSync[0];
   assign portMatchSync = pinSync[1];
   assign t3OvfSync = pinSync[2];
   assign cmpSync = pinSync[3];

   // pins come from outside the clock domain; the reset pin is synced as a request
   // so that the flop reset value means no reset and no false reset follows release
   pmc_sync #(.WIDTH(4)) u_sync
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .asyncIn({comparatorOut, timer3Overflow, portMatch, !resetPin_n}),
      .syncOut(pinSync)
   );

   // ---------------------------------------------------------------
   // bus slave: ack one cycle after the strobe, dropped the next cycle
   // ---------------------------------------------------------------
   assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wbWrite = wbHit && wb_we_i && wb_sel_i[0];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wbHit;
   end

   // general flags and mode requests; idle request self-clears once in idle, stop request only on reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         generalFlags_r <= PMC_POWER_CTRL_RST[PMC_FLAGS_MSB:PMC_FLAGS_LSB];
         idleReq_r <= 1'b0;
         stopReq_r <= 1'b0;
      end
      else if (resetEvent)
      begin
         generalFlags_r <= PMC_POWER_CTRL_RST[PMC_FLAGS_MSB:PMC_FLAGS_LSB];
         idleReq_r <= 1'b0;
         stopReq_r <= 1'b0;
      end
      else
      begin
         if (wbWrite && wb_adr_i == PMC_POWER_CTRL_OFS)
         begin
            generalFlags_r <= wb_dat_i[PMC_FLAGS_MSB:PMC_FLAGS_LSB];
            stopReq_r <= wb_dat_i[PMC_STOP_BIT] | stopReq_r;
            idleReq_r <= wb_dat_i[PMC_IDLE_BIT] | idleReq_r;
         end
         else if (mode_r == PMC_IDLE && irqPending)
            idleReq_r <= 1'b0;
         else if (mode_r == PMC_IDLE || mode_r == PMC_STOP)
         begin
            idleReq_r <= 1'b0;
            stopReq_r <= stopReq_r;
         end
      end
   end

   // oscillator, regulator and wake configuration registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         suspend_r <= PMC_OSC_CTRL_RST[PMC_SUSPEND_BIT];
         stopShutdown_r <= PMC_REG_CTRL_RST[PMC_STOP_SHUTDOWN_BIT];
         wakeCfg_r <= PMC_WAKE_CFG_RST;
      end
      else if (resetEvent)
      begin
         suspend_r <= PMC_OSC_CTRL_RST[PMC_SUSPEND_BIT];
         stopShutdown_r <= PMC_REG_CTRL_RST[PMC_STOP_SHUTDOWN_BIT];
         wakeCfg_r <= PMC_WAKE_CFG_RST;
      end
      else
      begin
         if (suspendWake)
            suspend_r <= 1'b0;
         else if (wbWrite && wb_adr_i == PMC_OSC_CTRL_OFS)
            suspend_r <= wb_dat_i[PMC_SUSPEND_BIT];
         if (wbWrite && wb_adr_i == PMC_REG_CTRL_OFS)
            stopShutdown_r <= wb_dat_i[PMC_STOP_SHUTDOWN_BIT];
         if (wbWrite && wb_adr_i == PMC_WAKE_CFG_OFS)
            wakeCfg_r <= wb_dat_i[7:0];
      end
   end

   // ---------------------------------------------------------------
   // read path: idle and stop bits never read back as one
   // ---------------------------------------------------------------
   always_comb
   begin
      readMux = 8'h00;
      case (wb_adr_i)
         PMC_POWER_CTRL_OFS: readMux = {generalFlags_r, 2'b00};
         PMC_OSC_CTRL_OFS: readMux = 8'(suspend_r) << PMC_SUSPEND_BIT;
         PMC_REG_CTRL_OFS: readMux = {7'h00, stopShutdown_r};
         PMC_WAKE_CFG_OFS: readMux = wakeCfg_r;
         PMC_STATUS_OFS: readMux = {5'h00, powerMode};
         default: readMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wb_dat_o <= 32'h0000_0000;
      else if (wbHit && !wb_we_i)
         wb_dat_o <= {24'h00_0000, readMux};
   end

   // ---------------------------------------------------------------
   // reset sources: watchdog in idle, clock detector in stop
   // ---------------------------------------------------------------
   pmc_timeout #(.LIMIT(WATCHDOG_TIMEOUT_CYC), .WIDTH(32)) u_watchdog
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(wakeCfg_r[PMC_WATCHDOG_EN_BIT] && mode_r == PMC_IDLE),
      .kick(1'b0),
      .expired(watchdogExpired)
   );

   // detector counts cycles without the cpu clock; in stop that clock is gone
   pmc_timeout #(.LIMIT(CLK_LOSS_TIMEOUT_CYC), .WIDTH(32)) u_clk_loss
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(clkLossActive),
      .kick(cpuClkPresent && mode_r != PMC_STOP),
      .expired(clkLossExpired)
   );

   // with the regulator off only the pin can bring the device back
   assign resetEvent = !resetPinSync_n ||
      ((watchdogExpired || clkLossExpired) && !(mode_r == PMC_STOP && stopShutdown_r));

   assign suspendWake = mode_r == PMC_SUSPEND &&
      (portMatchSync || t3OvfSync || (wakeCfg_r[PMC_CMP_WAKE_EN_BIT] && !cmpSync));

   // ---------------------------------------------------------------
   // mode sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      mode_nxt = mode_r;
      case (mode_r)
         PMC_RUN:
            if (instrDone && stopReq_r)
               mode_nxt = PMC_STOP;
            else if (instrDone && idleReq_r)
               mode_nxt = PMC_IDLE;
            else if (instrDone && suspend_r)
               mode_nxt = PMC_SUSPEND;
         PMC_IDLE:
            if (irqPending)
               mode_nxt = PMC_RUN;
         PMC_STOP:
            mode_nxt = PMC_STOP;
         PMC_SUSPEND:
            if (suspendWake)
               mode_nxt = PMC_WAKEUP;
         PMC_WAKEUP:
            if (settle_r == 8'h00)
               mode_nxt = PMC_RUN;
         default: mode_nxt = PMC_RUN;
      endcase
   end

   // any reset returns to run with the cpu restarted at the vector
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         mode_r <= PMC_RUN;
      else if (resetEvent)
         mode_r <= PMC_RUN;
      else
         mode_r <= mode_nxt;
   end

   // oscillator settle count while waking from suspend
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         settle_r <= 8'h00;
      else if (suspendWake)
         settle_r <= 8'(PMC_OSC_SETTLE_CYC - 1);
      else if (settle_r != 8'h00)
         settle_r <= settle_r - 8'h01;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cpuResetReq <= 1'b1;
      else
         cpuResetReq <= resetEvent;
   end

   // ---------------------------------------------------------------
   // clock and power gating outputs
   // ---------------------------------------------------------------
   assign resetVector = PMC_RESET_VECTOR;
   assign cpuHalt = mode_r != PMC_RUN;
   assign intOscEnable = mode_r == PMC_RUN || mode_r == PMC_IDLE || mode_r == PMC_WAKEUP;
   assign periphClkEnable = mode_r == PMC_RUN || mode_r == PMC_IDLE;
   assign timer3ClkEnable = periphClkEnable || (mode_r == PMC_SUSPEND && wakeCfg_r[PMC_T3_EXT_CLK_BIT]);
   assign portMatchEnable = mode_r != PMC_STOP;
   assign clkLossActive = wakeCfg_r[PMC_CLK_LOSS_EN_BIT];
   assign regulatorEnable = !(mode_r == PMC_STOP && stopShutdown_r);
   assign powerMode = mode_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   idle_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_r == PMC_RUN && instrDone && idleReq_r && !stopReq_r && !resetEvent |=> mode_r == PMC_IDLE)
      else $error("idle not entered");
   idle_clocks_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_r == PMC_IDLE |-> periphClkEnable && intOscEnable)
      else $error("clocks gated in idle");
   idle_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_r == PMC_IDLE && irqPending && !resetEvent |=> mode_r == PMC_RUN && !idleReq_r)
      else $error("idle not woken");
   stop_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_r == PMC_STOP && !resetEvent |=> mode_r == PMC_STOP)
      else $error("stop left without reset");
   stop_osc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_r == PMC_STOP |-> !intOscEnable && !periphClkEnable && cpuHalt)
      else $error("stop clocks running");
   reg_shut_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_r == PMC_STOP && stopShutdown_r && resetPinSync_n |=> mode_r == PMC_STOP)
      else $error("internal reset with regulator off");
   ctrl_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wbHit && !wb_we_i && wb_adr_i == PMC_POWER_CTRL_OFS |=> wb_dat_o[1:0] == 2'b00)
      else $error("mode bits read nonzero");
   susp_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      suspendWake && !resetEvent |=> mode_r == PMC_WAKEUP && cpuHalt && intOscEnable)
      else $error("suspend wake not settling");
   reset_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      resetEvent |=> mode_r == PMC_RUN && cpuResetReq)
      else $error("reset did not restart");
   cov_idle_c: cover property (@(posedge clk_sys) disable iff (!rst_n) mode_r == PMC_IDLE ##1 mode_r == PMC_RUN);
   cov_stop_c: cover property (@(posedge clk_sys) disable iff (!rst_n) mode_r == PMC_STOP ##1 cpuResetReq);
   cov_susp_c: cover property (@(posedge clk_sys) disable iff (!rst_n) mode_r == PMC_WAKEUP ##1 mode_r == PMC_RUN);
endmodule

// ### include/pmc_pkg.sv
/*
 power mode control package: register offsets, field positions, reset values, timing constants and modes.
 assumes a 32-bit classic wishbone slave with word-aligned registers.
*/
package pmc_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] PMC_POWER_CTRL_OFS = 8'h00;
   localparam logic [7:0] PMC_OSC_CTRL_OFS = 8'h04;
   localparam logic [7:0] PMC_REG_CTRL_OFS = 8'h08;
   localparam logic [7:0] PMC_WAKE_CFG_OFS = 8'h0c;
   localparam logic [7:0] PMC_STATUS_OFS = 8'h10;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PMC_IDLE_BIT = 0;
   localparam int PMC_STOP_BIT = 1;
   localparam int PMC_FLAGS_LSB = 2;
   localparam int PMC_FLAGS_MSB = 7;
   localparam int PMC_SUSPEND_BIT = 5;
   localparam int PMC_STOP_SHUTDOWN_BIT = 0;
   localparam int PMC_CMP_WAKE_EN_BIT = 0;
   localparam int PMC_CLK_LOSS_EN_BIT = 1;
   localparam int PMC_WATCHDOG_EN_BIT = 2;
   localparam int PMC_T3_EXT_CLK_BIT = 3;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] PMC_POWER_CTRL_RST = 8'h00;
   localparam logic [7:0] PMC_OSC_CTRL_RST = 8'h00;
   localparam logic [7:0] PMC_REG_CTRL_RST = 8'h00;
   localparam logic [7:0] PMC_WAKE_CFG_RST = 8'h06;
   localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int PMC_CLK_MHZ = 100;
   localparam int PMC_OSC_SETTLE_NS = 200;
   localparam int PMC_OSC_SETTLE_CYC = (PMC_OSC_SETTLE_NS * PMC_CLK_MHZ + 999) / 1000;
   localparam int PMC_CLK_LOSS_TIMEOUT_US = 100;
   localparam int PMC_CLK_LOSS_TIMEOUT_CYC = PMC_CLK_LOSS_TIMEOUT_US * PMC_CLK_MHZ;
   localparam int PMC_WATCHDOG_TIMEOUT_CYC = 65536;
   // ---------------------------------------------------------------
   // modes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {PMC_RUN, PMC_IDLE, PMC_STOP, PMC_SUSPEND, PMC_WAKEUP} pmc_mode_e;
endpackage

// ### hdl/pmc_sync.sv
/*
 two flip-flop synchroniser for asynchronous level inputs.
 assumes the input is a slow level; pulses shorter than one clock may be missed.
*/
`timescale 1ns/100ps
module pmc_sync
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // data
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_r;

   // first stage is read only by the second
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         syncOut <= '0;
      end
      else
      begin
         meta_r <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule

// ### hdl/pmc_timeout.sv
/*
 timeout counter: counts while enabled, fires a one-cycle pulse at LIMIT, clears when disabled.
 assumes LIMIT is at least one.
*/
`timescale 1ns/100ps
module pmc_timeout
#(
   parameter int LIMIT = 16,
   parameter int WIDTH = 32
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic enable,
   input wire logic kick,
   output logic expired
);
   logic [WIDTH-1:0] count_r;

   // restart on kick or when disabled
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= '0;
         expired <= 1'b0;
      end
      else if (!enable || kick)
      begin
         count_r <= '0;
         expired <= 1'b0;
      end
      else
      begin
         expired <= (count_r == WIDTH'(LIMIT - 1));
         count_r <= (count_r == WIDTH'(LIMIT - 1)) ? '0 : count_r + 1'b1;
      end
   end
endmodule

// ### test/power_mode_control_tb_top.sv
/*
 self-checking bench for pmc_power_mode_control: register access, idle, stop and suspend entry and wake.
 assumes pmc_pkg and the design files are compiled first; the bench drives every design input itself.
*/
`timescale 1ns/100ps
module power_mode_control_tb_top
   import pmc_pkg::*;
;
   // ---------------------------------------------------------------
   // signals and settings
   // ---------------------------------------------------------------
   // short counts keep each timeout scenario to a few dozen cycles
   localparam int CLK_LOSS_CYC = 16;
   localparam int WATCHDOG_CYC = 32;
   localparam int RUN_LIMIT = 20000;
   localparam logic [7:0] RST_TAB [6] = '{PMC_POWER_CTRL_RST, PMC_OSC_CTRL_RST, PMC_REG_CTRL_RST,
      PMC_WAKE_CFG_RST, 8'h00, 8'h00};
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0, wbDatO;
   logic wbAck;
   logic instrDone = 1'b0, irqPending = 1'b0, cpuClkPresent = 1'b1;
   logic resetPin_n = 1'b1, portMatch = 1'b0, timer3Overflow = 1'b0, comparatorOut = 1'b1;
   logic cpuHalt, cpuResetReq, intOscEnable, periphClkEnable, timer3ClkEnable;
   logic portMatchEnable, clkLossActive, regulatorEnable;
   logic [15:0] resetVector;
   logic [2:0] powerMode;
   int bad_count = 0;
   int n_tests = 0;
   int cycleCount = 0;
   logic [31:0] seed = 32'heb63;

   // ---------------------------------------------------------------
   // design under test
   // ---------------------------------------------------------------
   pmc_power_mode_control #(.CLK_LOSS_TIMEOUT_CYC(CLK_LOSS_CYC), .WATCHDOG_TIMEOUT_CYC(WATCHDOG_CYC)) dut
   (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .instrDone(instrDone), .irqPending(irqPending), .cpuClkPresent(cpuClkPresent),
      .cpuHalt(cpuHalt), .cpuResetReq(cpuResetReq), .resetVector(resetVector),
      .resetPin_n(resetPin_n), .portMatch(portMatch), .timer3Overflow(timer3Overflow),
      .comparatorOut(comparatorOut), .intOscEnable(intOscEnable), .periphClkEnable(periphClkEnable),
      .timer3ClkEnable(timer3ClkEnable), .portMatchEnable(portMatchEnable), .clkLossActive(clkLossActive),
      .regulatorEnable(regulatorEnable), .powerMode(powerMode)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;

   // galois lfsr; a fixed start value keeps every run identical
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h80200003 : (s >> 1);
   endfunction

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // classic single cycle; held until ack is sampled high, then released
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd, input logic [3:0] sel,
      output logic [31:0] rd);
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= sel;
      wbDatI <= {24'h0, wd};
      do
         @(posedge clk_sys);
      while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
      logic [31:0] d;
      wb(1'b1, adr, wd, 4'hf, d);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp, input string what);
      logic [31:0] d;
      wb(1'b0, adr, 8'h00, 4'hf, d);
      chk(d, {24'h0, exp}, what);
   endtask

   // one completed instruction
   task automatic step();
      @(posedge clk_sys);
      instrDone <= 1'b1;
      @(posedge clk_sys);
      instrDone <= 1'b0;
   endtask

   task automatic wait_mode(input logic [2:0] m, input int lim);
      int i;
      i = 0;
      while (powerMode !== m && i < lim)
      begin
         @(posedge clk_sys);
         i++;
      end
      chk({29'h0, powerMode}, {29'h0, m}, "power mode");
   endtask

   // waits for the reset request pulse and checks the restart address
   task automatic wait_rst(input int lim);
      int i;
      i = 0;
      while (cpuResetReq !== 1'b1 && i < lim)
      begin
         @(posedge clk_sys);
         i++;
      end
      chk(cpuResetReq, 1'b1, "reset request");
      chk(resetVector, 16'h0000, "restart address");
   endtask

   // hang guard
   always @(posedge clk_sys)
   begin
      cycleCount++;
      if (cycleCount == RUN_LIMIT)
      begin
         bad_count++;
         $display("wrong value at %0t: run timed out", $time);
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic [7:0] f;
      int n;
      repeat (3) @(posedge clk_sys);
      chk(cpuResetReq, 1'b1, "reset request in reset");
      rst_n <= 1'b1;
      @(posedge clk_sys);
      // register reset values, unmapped place, masked and unmapped writes
      for (int i = 0; i < 6; i++)
         rd_chk(8'(i * 4), RST_TAB[i], "reset value");
      chk({cpuHalt, regulatorEnable}, 2'b01, "run after reset");
      seed = lfsr(seed);
      f = seed[7:0] & 8'hfc;
      wr(PMC_POWER_CTRL_OFS, f);
      wb(1'b1, PMC_POWER_CTRL_OFS, 8'hff, 4'h0, d);
      wr(8'h14, 8'hff);
      rd_chk(8'h14, 8'h00, "unmapped read");
      rd_chk(PMC_POWER_CTRL_OFS, f, "flags read back");
      $display("test registers done");
      // idle entry and interrupt wake with random flags and delays
      for (int k = 0; k < 3; k++)
      begin
         seed = lfsr(seed);
         f = seed[7:0] & 8'hfc;
         wr(PMC_POWER_CTRL_OFS, f | 8'h01);
         rd_chk(PMC_POWER_CTRL_OFS, f, "idle bit reads zero");
         // irq stays low while the setting instruction executes, so the later wake is never lost
         step();
         wait_mode(PMC_IDLE, 4);
         chk(cpuHalt, 1'b1, "halt in idle");
         chk(periphClkEnable & intOscEnable, 1'b1, "clocks in idle");
         repeat (seed[10:8] + 1) @(posedge clk_sys);
         irqPending <= 1'b1;
         wait_mode(PMC_RUN, 4);
         irqPending <= 1'b0;
         chk(cpuHalt, 1'b0, "cpu resumes");
         rd_chk(PMC_POWER_CTRL_OFS, f, "flags kept over idle");
      end
      // watchdog ends an idle period with no interrupt
      wr(PMC_POWER_CTRL_OFS, 8'h81);
      step();
      wait_mode(PMC_IDLE, 4);
      wait_rst(WATCHDOG_CYC + 8);
      wait_mode(PMC_RUN, 4);
      rd_chk(PMC_POWER_CTRL_OFS, 8'h00, "flags cleared by reset");
      $display("test idle done");
      // stop: interrupt ignored, missing-clock detector resets
      wr(PMC_POWER_CTRL_OFS, 8'h42);
      rd_chk(PMC_POWER_CTRL_OFS, 8'h40, "stop bit reads zero");
      step();
      wait_mode(PMC_STOP, 4);
      chk({intOscEnable, periphClkEnable, clkLossActive, regulatorEnable}, 4'h3, "stop clocks");
      irqPending <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk({29'h0, powerMode}, {29'h0, PMC_STOP}, "interrupt ignored in stop");
      irqPending <= 1'b0;
      wait_rst(CLK_LOSS_CYC + 8);
      wait_mode(PMC_RUN, 4);
      rd_chk(PMC_POWER_CTRL_OFS, 8'h00, "registers reset after stop");
      // stop with regulator shutdown: only the pin resets
      wr(PMC_REG_CTRL_OFS, 8'h01);
      wr(PMC_POWER_CTRL_OFS, 8'h02);
      step();
      wait_mode(PMC_STOP, 4);
      chk(regulatorEnable, 1'b0, "regulator off");
      rd_chk(PMC_STATUS_OFS, 8'(PMC_STOP), "status in stop");
      repeat (CLK_LOSS_CYC + 8) @(posedge clk_sys);
      chk({29'h0, powerMode}, {29'h0, PMC_STOP}, "detector cannot reset");
      resetPin_n <= 1'b0;
      wait_rst(8);
      resetPin_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wait_mode(PMC_RUN, 4);
      rd_chk(PMC_REG_CTRL_OFS, 8'h00, "shutdown cleared");
      $display("test stop done");
      // suspend: each wake source, a disabled comparator, oscillator restart
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         f = {4'h0, seed[0], 2'b11, k == 2};
         wr(PMC_WAKE_CFG_OFS, f);
         wr(PMC_OSC_CTRL_OFS, 8'h20);
         step();
         wait_mode(PMC_SUSPEND, 4);
         chk({cpuHalt, intOscEnable, periphClkEnable}, 3'h4, "suspend halts");
         chk({portMatchEnable, timer3ClkEnable}, {1'b1, seed[0]}, "suspend wake logic");
         if (k == 3)
         begin
            comparatorOut <= 1'b0;
            repeat (8) @(posedge clk_sys);
            chk({29'h0, powerMode}, {29'h0, PMC_SUSPEND}, "comparator disabled");
         end
         portMatch <= (k == 0 || k == 3);
         timer3Overflow <= (k == 1);
         comparatorOut <= (k != 2);
         wait_mode(PMC_WAKEUP, 6);
         chk({intOscEnable, cpuHalt}, 2'b11, "oscillator restarts first");
         n = 0;
         while (powerMode === PMC_WAKEUP && n < 100)
         begin
            @(posedge clk_sys);
            n++;
         end
         chk(n, PMC_OSC_SETTLE_CYC, "settle cycles");
         portMatch <= 1'b0;
         timer3Overflow <= 1'b0;
         comparatorOut <= 1'b1;
         chk({29'h0, powerMode}, {29'h0, PMC_RUN}, "resumes after suspend");
         rd_chk(PMC_OSC_CTRL_OFS, 8'h00, "suspend bit cleared");
      end
      // reset ends suspend
      wr(PMC_OSC_CTRL_OFS, 8'h20);
      step();
      wait_mode(PMC_SUSPEND, 4);
      resetPin_n <= 1'b0;
      wait_rst(8);
      resetPin_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wait_mode(PMC_RUN, 4);
      rd_chk(PMC_WAKE_CFG_OFS, PMC_WAKE_CFG_RST, "config reset");
      $display("test suspend done");
      complete_run();
   end
endmodule
